// [comparator_control_logic.sv]
// Comparator control registers, result path, wake and interrupt logic
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module comparator_control_logic (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [comp_ctrl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [comp_ctrl_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [comp_ctrl_pkg::DATA_W-1:0] regRdData,
    // Analog comparator and timer2 clock
    input wire logic compRaw,
    input wire logic timer2Clock,
    output logic compPower,
    output comp_ctrl_pkg::minus_sel_t minusSel,
    output comp_ctrl_pkg::plus_sel_t plusSel,
    output logic rangeHigh,
    output logic rangeLow,
    output logic [3:0] ladderLevel,
    // Port A pin 0 drive
    output logic portAPin0Out,
    output logic portAPin0Oe_n,
    // Result, wake and interrupt
    output logic compResultOut,
    output logic wakeReq,
    output logic irq
);
    import comp_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sel;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic [DATA_W-1:0] rdData;
        logic resPrev;
        logic outRes;
        logic t2Prev;
        logic wake;
        logic pinOut;
        logic pinOe_n;
        logic irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic resultSync;
    logic t2Sync;
    logic effRes;
    logic invRes;
    logic t2Rise;
    logic [STAT_W-1:0] statSet;
    logic [STAT_W-1:0] statClr;

    pin_sync #(.STAGES(SYNC_STAGES)) u_res_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn(compRaw),
        .levelOut(resultSync)
    );

    pin_sync #(.STAGES(SYNC_STAGES)) u_t2_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn(timer2Clock),
        .levelOut(t2Sync)
    );

    always_comb begin
        s_nxt = s_r;
        // Unpowered comparator reads as low
        effRes = s_r.ctrl[CTRL_EN_BIT] & resultSync;
        invRes = effRes ^ s_r.ctrl[CTRL_INV_BIT];
        t2Rise = t2Sync & ~s_r.t2Prev;
        s_nxt.t2Prev = t2Sync;
        if (s_r.ctrl[CTRL_SAMPLE_BIT]) begin
            if (t2Rise) begin
                s_nxt.outRes = invRes;
            end
        end else begin
            s_nxt.outRes = invRes;
        end
        s_nxt.resPrev = effRes;
        s_nxt.wake = s_r.sel[SEL_WAKE_BIT] & (effRes != s_r.resPrev);
        statSet = '0;
        statSet[STAT_RISE_BIT] = s_nxt.outRes & ~s_r.outRes;
        statSet[STAT_FALL_BIT] = ~s_nxt.outRes & s_r.outRes;
        statClr = '0;
        if (regWr) begin
            unique case (regAddr)
                ADDR_CTRL: begin
                    // Result bit is not writable
                    s_nxt.ctrl = regWrData;
                    s_nxt.ctrl[CTRL_RES_BIT] = 1'b0;
                end
                ADDR_SEL: s_nxt.sel = regWrData;
                ADDR_STATUS: statClr = regWrData[STAT_W-1:0];
                ADDR_MASK: s_nxt.mask = regWrData[STAT_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        s_nxt.status = (s_r.status & ~statClr) | statSet;
        s_nxt.rdData = '0;
        if (regRd) begin
            unique case (regAddr)
                ADDR_CTRL: begin
                    s_nxt.rdData = s_r.ctrl;
                    s_nxt.rdData[CTRL_RES_BIT] = effRes;
                end
                ADDR_STATUS: s_nxt.rdData = {{(DATA_W-STAT_W){1'b0}}, s_r.status};
                ADDR_MASK: s_nxt.rdData = {{(DATA_W-STAT_W){1'b0}}, s_r.mask};
                default: s_nxt.rdData = '0;
            endcase
        end
        s_nxt.pinOut = s_nxt.sel[SEL_OUT_BIT] & s_nxt.outRes;
        s_nxt.pinOe_n = ~s_nxt.sel[SEL_OUT_BIT];
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '{ctrl: CTRL_RESET, sel: SEL_RESET, status: STAT_RESET,
                     mask: MASK_RESET, rdData: '0, resPrev: 1'b0, outRes: 1'b0,
                     t2Prev: 1'b0, wake: 1'b0, pinOut: 1'b0, pinOe_n: 1'b1,
                     irq: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regRdData = s_r.rdData;
    assign compPower = s_r.ctrl[CTRL_EN_BIT];
    assign minusSel = minus_sel_t'(s_r.ctrl[CTRL_MINUS_LSB +: 3]);
    assign plusSel = plus_sel_t'(s_r.ctrl[CTRL_PLUS_BIT]);
    assign rangeHigh = s_r.sel[SEL_HIGH_BIT];
    assign rangeLow = s_r.sel[SEL_LOW_BIT];
    assign ladderLevel = s_r.sel[SEL_LEVEL_LSB +: 4];
    assign portAPin0Out = s_r.pinOut;
    assign portAPin0Oe_n = s_r.pinOe_n;
    assign compResultOut = s_r.outRes;
    assign wakeReq = s_r.wake;
    assign irq = s_r.irq;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence ctrl_write_s;
        regWr && regAddr == ADDR_CTRL;
    endsequence

    power_follows_a: assert property (ctrl_write_s |=> compPower == $past(regWrData[7]))
        else $error("power bit does not follow control write");

    result_read_a: assert property (regRd && regAddr == ADDR_CTRL |=>
            regRdData[CTRL_RES_BIT] == ($past(compPower) & $past(resultSync)))
        else $error("result readback wrong");

    unsampled_path_a: assert property (!s_r.ctrl[CTRL_SAMPLE_BIT] && !regWr |=>
            compResultOut == ($past(effRes) ^ $past(s_r.ctrl[CTRL_INV_BIT])))
        else $error("unsampled output differs from result");

    sampled_hold_a: assert property (s_r.ctrl[CTRL_SAMPLE_BIT] && !t2Rise |=>
            $stable(compResultOut))
        else $error("sampled output moved without timer2 edge");

    invert_path_a: assert property (ctrl_write_s ##1 (!regWr && !s_r.ctrl[CTRL_SAMPLE_BIT])
            |=> compResultOut == (effRes ^ s_r.ctrl[CTRL_INV_BIT]) || $changed(effRes))
        else $error("inversion not applied");

    minus_route_a: assert property (ctrl_write_s |=> minusSel == $past(regWrData[3:1]))
        else $error("minus selection not routed");

    pin_drive_a: assert property (!portAPin0Oe_n |-> portAPin0Out == compResultOut)
        else $error("pin 0 does not carry result");

    wake_change_a: assert property (s_r.sel[SEL_WAKE_BIT] && $changed(effRes) |=> wakeReq)
        else $error("wake missing on result change");

    ladder_route_a: assert property (regWr && regAddr == ADDR_SEL |=>
            {rangeHigh, rangeLow, ladderLevel} == $past(regWrData[5:0]))
        else $error("ladder selection not routed");

    irq_level_a: assert property (irq == |(s_r.status & s_r.mask))
        else $error("interrupt does not match status and mask");

    set_wins_a: assert property (statSet[STAT_RISE_BIT] |=> s_r.status[STAT_RISE_BIT])
        else $error("result event lost");

    // Further register write sequences
    sequence sel_write_s;
        regWr && regAddr == ADDR_SEL;
    endsequence

    sequence status_write_s;
        regWr && regAddr == ADDR_STATUS;
    endsequence

    sequence mask_write_s;
        regWr && regAddr == ADDR_MASK;
    endsequence

    // Raw comparator level held long enough to pass the filter
    sequence raw_high_s;
        compRaw [*4];
    endsequence

    sequence raw_low_s;
        !compRaw [*4];
    endsequence

    sequence t2_edge_s;
        !t2Sync ##1 t2Sync;
    endsequence

    // Control field routing and register readback
    result_ro_a: assert property (ctrl_write_s |=>
            !s_r.ctrl[CTRL_RES_BIT])
        else $error("result bit took write data");

    sample_bit_a: assert property (ctrl_write_s |=>
            s_r.ctrl[CTRL_SAMPLE_BIT] == $past(regWrData[5]))
        else $error("sample bit not stored");

    invert_bit_a: assert property (ctrl_write_s |=>
            s_r.ctrl[CTRL_INV_BIT] == $past(regWrData[4]))
        else $error("invert bit not stored");

    plus_route_a: assert property (ctrl_write_s |=>
            plusSel == $past(regWrData[0]))
        else $error("plus selection not routed");

    unpowered_read_a: assert property (regRd && regAddr == ADDR_CTRL && !compPower |=>
            !regRdData[CTRL_RES_BIT])
        else $error("unpowered result reads high");

    sel_hidden_a: assert property (regRd && regAddr == ADDR_SEL |=>
            regRdData == '0)
        else $error("write-only select register readable");

    read_idle_a: assert property (!regRd |=>
            regRdData == '0)
        else $error("read data without read strobe");

    // Pin drive
    pin_enable_a: assert property (sel_write_s |=>
            portAPin0Oe_n == !$past(regWrData[7]))
        else $error("pin 0 enable not routed");

    pin_release_a: assert property (portAPin0Oe_n |->
            !portAPin0Out)
        else $error("pin 0 data while released");

    // Wake request
    wake_enable_a: assert property (sel_write_s |=>
            s_r.sel[SEL_WAKE_BIT] == $past(regWrData[6]))
        else $error("wake enable not stored");

    wake_quiet_a: assert property (!s_r.sel[SEL_WAKE_BIT] |=>
            !wakeReq)
        else $error("wake while disabled");

    wake_still_a: assert property (!$changed(effRes) |=>
            !wakeReq)
        else $error("wake without result change");

    // Events and interrupt
    mask_route_a: assert property (mask_write_s |=>
            s_r.mask == $past(regWrData[STAT_W-1:0]))
        else $error("mask not stored");

    status_clear_a: assert property (status_write_s ##0
            (regWrData[STAT_RISE_BIT] && !statSet[STAT_RISE_BIT]) |=> !s_r.status[STAT_RISE_BIT])
        else $error("status bit not cleared");

    rise_event_a: assert property ($rose(compResultOut) |->
            s_r.status[STAT_RISE_BIT])
        else $error("rise of result not flagged");

    fall_event_a: assert property ($fell(compResultOut) |->
            s_r.status[STAT_FALL_BIT])
        else $error("fall of result not flagged");

    fall_kept_a: assert property (statSet[STAT_FALL_BIT] |=>
            s_r.status[STAT_FALL_BIT])
        else $error("fall event lost");

    irq_masked_a: assert property (s_r.mask == '0 |->
            !irq)
        else $error("interrupt with all events masked");

    // Sampling and synchronisation
    sampled_update_a: assert property (t2_edge_s ##0 s_r.ctrl[CTRL_SAMPLE_BIT] |=>
            compResultOut == $past(invRes))
        else $error("sampled output missed timer2 edge");

    sync_high_a: assert property (raw_high_s |=>
            resultSync)
        else $error("steady high result not synchronised");

    sync_low_a: assert property (raw_low_s |=>
            !resultSync)
        else $error("steady low result not synchronised");
endmodule

// [comp_ctrl_pkg.sv]
// Constants and types for the comparator control block
// Function
// - Bit 7 of control powers the comparator; read/write, clears at reset.
// - Control bit 6 is read-only and shows plus greater than minus.
// - Control bit 5 resamples the result on rising timer2 clock edges.
// - Control bit 4 inverts the result output polarity.
// - Control bits 3:1 route the minus input; other codes reserved.
// - Control bit 0 routes the plus input: ladder or port A pin 4.
// - Write-only select bit 7 drives the result onto port A pin 0.
// - Select bit 6 wakes the device when the result bit changes.
// - Select bits 5 and 4 choose high and low ladder range.
// - Select bits 3:0 pick one of sixteen ladder taps.
// - The comparator result is an interrupt request source.
package comp_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h18;
    localparam logic [7:0] ADDR_SEL = 8'h19;
    localparam logic [7:0] ADDR_STATUS = 8'h1a;
    localparam logic [7:0] ADDR_MASK = 8'h1b;
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_RES_BIT = 6;
    localparam int CTRL_SAMPLE_BIT = 5;
    localparam int CTRL_INV_BIT = 4;
    localparam int CTRL_MINUS_LSB = 1;
    localparam int CTRL_PLUS_BIT = 0;
    localparam int SEL_OUT_BIT = 7;
    localparam int SEL_WAKE_BIT = 6;
    localparam int SEL_HIGH_BIT = 5;
    localparam int SEL_LOW_BIT = 4;
    localparam int SEL_LEVEL_LSB = 0;
    localparam int STAT_RISE_BIT = 0;
    localparam int STAT_FALL_BIT = 1;
    localparam int STAT_W = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [2:0] {
        MINUS_PORT_A_PIN3 = 3'b000,
        MINUS_PORT_A_PIN4 = 3'b001,
        MINUS_BANDGAP = 3'b010,
        MINUS_LADDER = 3'b011,
        MINUS_RSVD4 = 3'b100,
        MINUS_PORT_B_PIN7 = 3'b101,
        MINUS_RSVD6 = 3'b110,
        MINUS_RSVD7 = 3'b111
    } minus_sel_t;
    typedef enum logic {
        PLUS_LADDER = 1'b0,
        PLUS_PORT_A_PIN4 = 1'b1
    } plus_sel_t;
endpackage

// [pin_sync.sv]
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
module pin_sync #(
    parameter int STAGES = 3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Asynchronous level in, filtered level out
    input wire logic asyncIn,
    output logic levelOut
);
    logic [STAGES-1:0] chain_r;
    logic level_r;

    // Level moves only when the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chain_r <= '0;
            level_r <= 1'b0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], asyncIn};
            if (chain_r[STAGES-1] == chain_r[STAGES-2]) begin
                level_r <= chain_r[STAGES-1];
            end
        end
    end

    assign levelOut = level_r;
endmodule

// [comp_partner.sv]
// Analog comparator and timer2 clock source seen by the control block
`timescale 1ns/1ps
module comp_partner (
    // Bench controls
    input wire logic sys_clk,
    input wire logic plusAbove,
    input wire logic t2Run,
    input wire logic portADigitalInputEnable,
    // Device side
    input wire logic compPower,
    output logic compRaw,
    output logic timer2Clock
);
    initial begin
        compRaw = 1'b0;
        timer2Clock = 1'b0;
    end
    // Unpowered or leaking input wanders each cycle
    always @(posedge sys_clk) begin
        #3 compRaw <= (compPower && !portADigitalInputEnable) ? plusAbove : ~compRaw;
    end
    // Stands low while stopped
    always begin
        #35 timer2Clock = t2Run & ~timer2Clock;
    end
endmodule

// [testbench.sv]
// Register-level tests of the comparator control block
`timescale 1ns/1ps
module testbench;
    import comp_ctrl_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic compRaw, timer2Clock, compPower, rangeHigh, rangeLow, portAPin0Out, portAPin0Oe_n;
    logic compResultOut, wakeReq, irq, plusAbove = 1'b0, t2Run = 1'b0;
    logic portADigitalInputEnable = 1'b1;
    logic [3:0] ladderLevel;
    minus_sel_t minusSel;
    plus_sel_t plusSel;
    int miscompares = 0, n_compared = 0, k;
    comparator_control_logic dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .compRaw(compRaw), .timer2Clock(timer2Clock), .compPower(compPower),
        .minusSel(minusSel), .plusSel(plusSel), .rangeHigh(rangeHigh), .rangeLow(rangeLow),
        .ladderLevel(ladderLevel), .portAPin0Out(portAPin0Out),
        .portAPin0Oe_n(portAPin0Oe_n), .compResultOut(compResultOut), .wakeReq(wakeReq),
        .irq(irq));
    comp_partner partner (.sys_clk(sys_clk), .plusAbove(plusAbove), .t2Run(t2Run),
        .portADigitalInputEnable(portADigitalInputEnable),
        .compPower(compPower), .compRaw(compRaw), .timer2Clock(timer2Clock));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk("regRdData", exp, regRdData);
    endtask
    task automatic waitOut(input logic v);
        k = 0;
        while (compResultOut !== v && k < 40) begin
            cyc(1);
            k++;
        end
        chk("compResultOut", {7'h0, v}, {7'h0, compResultOut});
        if (k == 40) final_report();
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        portADigitalInputEnable <= 1'b0;
        cyc(4);
        chk("compPower", 8'h00, {7'h0, compPower});
        chk("portAPin0Oe_n", 8'h01, {7'h0, portAPin0Oe_n});
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_SEL, 8'h00);
        rd(8'h20, 8'h00);
        wr(ADDR_CTRL, 8'hff);
        chk("compPower", 8'h01, {7'h0, compPower});
        rd(ADDR_CTRL, 8'hbf);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CTRL, 8'h80 | 8'(i << 1) | 8'(i & 1));
            chk("minusSel", 8'(i), {5'h0, minusSel});
            chk("plusSel", 8'(i & 1), {7'h0, plusSel});
        end
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SEL, {2'b00, 2'(i), {4{i[0]}}});
            chk("range", 8'(i), {6'h0, rangeHigh, rangeLow});
            chk("ladderLevel", {4'h0, {4{i[0]}}}, {4'h0, ladderLevel});
        end
        wr(ADDR_CTRL, 8'h80);
        plusAbove <= 1'b1;
        waitOut(1'b1);
        rd(ADDR_CTRL, 8'hc0);
        wr(ADDR_CTRL, 8'h90);
        waitOut(1'b0);
        rd(ADDR_CTRL, 8'hd0);
        wr(ADDR_STATUS, 8'h03);
        rd(ADDR_STATUS, 8'h00);
        plusAbove <= 1'b0;
        waitOut(1'b1);
        rd(ADDR_STATUS, 8'h01);
        chk("irq", 8'h00, {7'h0, irq});
        wr(ADDR_MASK, 8'h01);
        cyc(1);
        chk("irq", 8'h01, {7'h0, irq});
        rd(ADDR_MASK, 8'h01);
        wr(ADDR_STATUS, 8'h01);
        cyc(1);
        chk("irq", 8'h00, {7'h0, irq});
        wr(ADDR_SEL, 8'hc0);
        chk("portAPin0Oe_n", 8'h00, {7'h0, portAPin0Oe_n});
        cyc(1);
        chk("portAPin0Out", 8'h01, {7'h0, portAPin0Out});
        plusAbove <= 1'b1;
        k = 0;
        repeat (20) begin
            cyc(1);
            k += int'(wakeReq === 1'b1);
        end
        chk("wakePulses", 8'h01, 8'(k));
        chk("portAPin0Out", 8'h00, {7'h0, portAPin0Out});
        wr(ADDR_CTRL, 8'ha0);
        cyc(20);
        chk("compResultOut", 8'h00, {7'h0, compResultOut});
        t2Run <= 1'b1;
        waitOut(1'b1);
        t2Run <= 1'b0;
        wr(ADDR_SEL, 8'h00);
        wr(ADDR_CTRL, 8'h84);
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_SEL, 8'(i));
            plusAbove <= (i >= 9);
            cyc(6);
            rd(ADDR_CTRL, {1'b1, i >= 9, 6'h04});
        end
        wr(ADDR_CTRL, 8'h00);
        chk("compPower", 8'h00, {7'h0, compPower});
        final_report();
    end
endmodule
